// *** logic/tcp_core.sv ***
// Counter core with prescaler, wrap logic and register slave
`timescale 1ns/1ps
module tcp_core
  import tcp_pkg::*;
(
  // Clock and reset
  input  wire logic         clock,
  input  wire logic         resetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [11:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output logic              pready,
  output logic [31:0]       prdata,
  output logic              pslverr,
  // System state
  input  wire logic         break_active,
  input  wire logic         break_clear_enable,
  // External clock pin, already synchronous
  input  wire logic         ext_timer_clock_pin,
  // Channel events and channel pin modes
  input  tcp_chan_ev_t      chan_ev,
  output logic [5:0]        chan_capture_en,
  output logic [5:0]        chan_buffered,
  // Counter state to the channel logic
  output logic [15:0]       count_value,
  output logic              wrap_pulse,
  // Pin direction and interrupt
  output logic              ext_pin_input_force,
  output logic              irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic        wrap_flag;
  logic        wrap_irq_enable;
  logic        counter_halt;
  logic [2:0]  clock_select;
  logic [15:0] wrap_limit;
  logic [7:0]  wrap_high_pend;
  logic        wrap_block;
  logic [15:0] count;
  logic [6:0]  prescaler;
  logic [7:0]  low_latch;
  logic        latch_held;
  logic        wrap_armed;
  logic [5:0]  channel_event_flag;
  logic [5:0]  channel_irq_enable;
  logic [5:0]  chan_armed;
  logic [5:0]  chan_mode;
  logic [5:0]  chan_buf_req;
  logic        wait_mode;
  logic        stop_mode;
  logic        port_direction_bit;
  logic        ext_prev;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic        acc;
  logic        wr;
  logic        rd;
  logic [7:0]  idx;
  logic        hit;
  logic [7:0]  wbyte;
  logic        clear_req;
  logic        tick;
  logic        run;
  logic        match;
  logic        wrap_set;
  logic        break_block;
  logic        bus_ok;

  // Index match against a register index
  function automatic logic is_idx(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  // Bus blocked in wait mode, except writes to mode control
  assign bus_ok = !wait_mode;
  assign acc    = psel && penable && bus_ok;
  assign wr     = acc && pwrite;
  assign rd     = acc && !pwrite;
  // Addresses above the decoded page map to an index that never hits
  assign idx    = (paddr[11:8] == 4'h0) ? {2'h0, paddr[7:2]} : 8'hFF;
  assign wbyte  = pwdata[7:0];
  assign hit    = is_idx(idx, TCP_IDX_STATUS) || is_idx(idx, TCP_IDX_CNT_HIGH)
               || is_idx(idx, TCP_IDX_CNT_LOW) || is_idx(idx, TCP_IDX_WRAP_HIGH)
               || is_idx(idx, TCP_IDX_WRAP_LOW)
               || is_idx(idx, TCP_IDX_CHAN_CTRL)
               || is_idx(idx, TCP_IDX_CHAN_FLAGS)
               || is_idx(idx, TCP_IDX_MODE_CTRL);
  // Flag clear steps in break only with clear enable
  assign break_block = break_active && !break_clear_enable;
  assign clear_req = wr && is_idx(idx, TCP_IDX_STATUS)
                  && wbyte[TCP_BIT_CLEAR];

  ////////////////////////////////////////////////////////////////////////////
  // Counter clock enable from prescaler or external pin
  always_comb begin
    if (clock_select == TCP_SEL_EXT) begin
      tick = ext_timer_clock_pin && !ext_prev;
    end else if (clock_select == TCP_SEL_RESET) begin
      tick = 1'b1;
    end else begin
      tick = (prescaler & ((7'h01 << clock_select) - 7'h01)) == 7'h00;
    end
  end

  // Counter advances unless halted, stopped or in break
  assign run   = !counter_halt && !stop_mode && !break_active;
  assign match = count == wrap_limit;
  assign wrap_set = run && tick && match && !wrap_block;

  // Pin edge history
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_timer_clock_pin;
    end
  end

  // Prescaler divides the bus clock
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prescaler <= TCP_PRE_RESET;
    end else if (clear_req) begin
      prescaler <= TCP_PRE_RESET;
    end else if (run) begin
      prescaler <= prescaler + 7'h01;
    end
  end

  // Counter with wrap at limit
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count <= TCP_CNT_RESET;
    end else if (clear_req) begin
      count <= TCP_CNT_RESET;
    end else if (run && tick) begin
      count <= match ? TCP_CNT_RESET : count + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status and control bits
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrap_irq_enable <= 1'b0;
      counter_halt    <= TCP_HALT_RESET;
      clock_select    <= TCP_SEL_RESET;
    end else if (wr && is_idx(idx, TCP_IDX_STATUS)) begin
      wrap_irq_enable <= wbyte[TCP_BIT_WRAP_IE];
      counter_halt    <= wbyte[TCP_BIT_HALT];
      clock_select    <= wbyte[TCP_SEL_LSB +: 3];
    end
  end

  // Wrap flag with two-step clear; set wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrap_flag  <= 1'b0;
      wrap_armed <= 1'b0;
    end else if (wrap_set) begin
      wrap_flag  <= 1'b1;
      wrap_armed <= 1'b0;
    end else if (rd && is_idx(idx, TCP_IDX_STATUS) && wrap_flag
                 && !break_block) begin
      wrap_armed <= 1'b1;
    end else if (wr && is_idx(idx, TCP_IDX_STATUS) && wrap_armed
                 && !wbyte[TCP_BIT_WRAP_FLAG] && !break_block) begin
      wrap_flag  <= 1'b0;
      wrap_armed <= 1'b0;
    end
  end

  // Wrap limit with high-byte hold-off
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wrap_limit     <= TCP_WRAP_RESET;
      wrap_high_pend <= TCP_WRAP_RESET[15:8];
      wrap_block     <= 1'b0;
    end else if (wr && is_idx(idx, TCP_IDX_WRAP_HIGH)) begin
      wrap_high_pend <= wbyte;
      wrap_block     <= 1'b1;
    end else if (wr && is_idx(idx, TCP_IDX_WRAP_LOW)) begin
      wrap_limit     <= {wrap_high_pend, wbyte};
      wrap_block     <= 1'b0;
    end
  end

  // Low byte latch on high read
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      low_latch  <= 8'h00;
      latch_held <= 1'b0;
    end else if (rd && is_idx(idx, TCP_IDX_CNT_HIGH) && !latch_held) begin
      low_latch  <= count[7:0];
      latch_held <= 1'b1;
    end else if (rd && is_idx(idx, TCP_IDX_CNT_LOW)) begin
      latch_held <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel control: enables, capture mode, buffered request
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      channel_irq_enable <= TCP_CHAN_RESET;
      chan_mode          <= TCP_CHAN_RESET;
      chan_buf_req       <= TCP_CHAN_RESET;
    end else if (wr && is_idx(idx, TCP_IDX_CHAN_CTRL)) begin
      channel_irq_enable <= pwdata[5:0];
      chan_mode          <= pwdata[13:8];
      chan_buf_req       <= pwdata[21:16] & TCP_BUF_CAPABLE;
    end
  end

  // Channel flags, two-step clear, set wins
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      channel_event_flag <= TCP_CHAN_RESET;
      chan_armed         <= TCP_CHAN_RESET;
    end else begin
      for (int i = 0; i < TCP_NUM_CHAN; i++) begin
        if (chan_ev.compare[i] && !stop_mode
            || chan_ev.capture[i] && chan_mode[i] && run) begin
          channel_event_flag[i] <= 1'b1;
          chan_armed[i]         <= 1'b0;
        end else if (rd && is_idx(idx, TCP_IDX_CHAN_FLAGS)
                     && channel_event_flag[i] && !break_block) begin
          chan_armed[i]         <= 1'b1;
        end else if (wr && is_idx(idx, TCP_IDX_CHAN_FLAGS) && chan_armed[i]
                     && !pwdata[i] && !break_block) begin
          channel_event_flag[i] <= 1'b0;
          chan_armed[i]         <= 1'b0;
        end
      end
    end
  end

  // Low-power mode and pin direction control
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_mode          <= 1'b0;
      stop_mode          <= 1'b0;
      port_direction_bit <= 1'b0;
    end else if (psel && penable && pwrite
                 && is_idx(idx, TCP_IDX_MODE_CTRL)) begin
      wait_mode          <= pwdata[TCP_BIT_WAIT];
      stop_mode          <= pwdata[TCP_BIT_STOP];
      port_direction_bit <= pwdata[TCP_BIT_PORT_DIR];
    end else if (irq) begin
      wait_mode          <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all registered
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_value         <= TCP_CNT_RESET;
      wrap_pulse          <= 1'b0;
      irq                 <= 1'b0;
      // Matches the value after reset: direction bit clear means input
      ext_pin_input_force <= 1'b1;
      chan_capture_en     <= TCP_CHAN_RESET;
      chan_buffered       <= TCP_CHAN_RESET;
    end else begin
      count_value         <= count;
      wrap_pulse          <= wrap_set;
      irq                 <= (wrap_flag && wrap_irq_enable)
                          || |(channel_event_flag & channel_irq_enable);
      ext_pin_input_force <= (clock_select == TCP_SEL_EXT)
                          || !port_direction_bit;
      chan_capture_en     <= chan_mode & {6{run}};
      chan_buffered       <= chan_buf_req;
    end
  end

  // APB answer: one cycle access phase, error on unmapped or in wait mode except mode control
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (psel && !penable) begin
      pready  <= 1'b1;
      pslverr <= !hit || (!bus_ok && !is_idx(idx, TCP_IDX_MODE_CTRL));
      prdata  <= 32'h0000_0000;
      if (is_idx(idx, TCP_IDX_STATUS)) begin
        prdata[7:0] <= {wrap_flag, wrap_irq_enable, counter_halt, 1'b0,
                        1'b0, clock_select};
      end else if (is_idx(idx, TCP_IDX_CNT_HIGH)) begin
        prdata[7:0] <= count[15:8];
      end else if (is_idx(idx, TCP_IDX_CNT_LOW)) begin
        prdata[7:0] <= latch_held ? low_latch : count[7:0];
      end else if (is_idx(idx, TCP_IDX_WRAP_HIGH)) begin
        prdata[7:0] <= wrap_limit[15:8];
      end else if (is_idx(idx, TCP_IDX_WRAP_LOW)) begin
        prdata[7:0] <= wrap_limit[7:0];
      end else if (is_idx(idx, TCP_IDX_CHAN_CTRL)) begin
        prdata[21:0] <= {chan_buf_req, 2'h0, chan_mode, 2'h0,
                         channel_irq_enable};
      end else if (is_idx(idx, TCP_IDX_CHAN_FLAGS)) begin
        prdata[5:0] <= channel_event_flag;
      end else if (is_idx(idx, TCP_IDX_MODE_CTRL)) begin
        prdata[2:0] <= {port_direction_bit, stop_mode, wait_mode};
      end
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule

// *** logic/tcp_pkg.sv ***
// Package: register map, field layout, reset values and timing constants
package tcp_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  TCP_IDX_CNT_HIGH   = 8'h22;
  localparam logic [7:0]  TCP_IDX_CNT_LOW    = 8'h23;
  // Indices chosen for registers that have no printed offset
  localparam logic [7:0]  TCP_IDX_STATUS     = 8'h20;
  localparam logic [7:0]  TCP_IDX_WRAP_HIGH  = 8'h24;
  localparam logic [7:0]  TCP_IDX_WRAP_LOW   = 8'h25;
  localparam logic [7:0]  TCP_IDX_CHAN_CTRL  = 8'h26;
  localparam logic [7:0]  TCP_IDX_CHAN_FLAGS = 8'h27;
  localparam logic [7:0]  TCP_IDX_MODE_CTRL  = 8'h28;

  // Status and control field positions
  localparam int          TCP_BIT_WRAP_FLAG  = 7;
  localparam int          TCP_BIT_WRAP_IE    = 6;
  localparam int          TCP_BIT_HALT       = 5;
  localparam int          TCP_BIT_CLEAR      = 4;
  localparam int          TCP_SEL_LSB        = 0;

  // Mode control field positions
  localparam int          TCP_BIT_WAIT       = 0;
  localparam int          TCP_BIT_STOP       = 1;
  localparam int          TCP_BIT_PORT_DIR   = 2;

  // Reset values, the external clock select code and the channel count
  localparam logic [2:0]  TCP_SEL_RESET      = 3'h0;
  localparam logic [2:0]  TCP_SEL_EXT        = 3'h7;
  localparam logic [15:0] TCP_WRAP_RESET     = 16'hFFFF;
  localparam logic [15:0] TCP_CNT_RESET      = 16'h0000;
  localparam logic        TCP_HALT_RESET     = 1'b1;
  localparam logic [5:0]  TCP_CHAN_RESET     = 6'h00;
  localparam logic [6:0]  TCP_PRE_RESET      = 7'h00;
  localparam int          TCP_NUM_CHAN       = 6;

  // Channels that can carry buffered compare output
  localparam logic [5:0]  TCP_BUF_CAPABLE    = 6'h15;

  // Clock rate and the highest external clock rate
  localparam int          TCP_CLK_MHZ        = 125;
  localparam int          TCP_EXT_MAX_MHZ    = 4;
  // Minimum bus cycles per external clock period
  localparam int          TCP_EXT_MIN_CYCLES =
    (TCP_CLK_MHZ + TCP_EXT_MAX_MHZ - 1) / TCP_EXT_MAX_MHZ;

  // Channel event inputs from the capture and compare logic
  typedef struct packed {
    logic [5:0] capture;
    logic [5:0] compare;
  } tcp_chan_ev_t;

endpackage

// *** tb/tcp_core_monitor.sv ***
// Checker on the counter core ports
`timescale 1ns/1ps
module tcp_core_monitor
  import tcp_pkg::*;
(
  // Bus side
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // Timer side
  input wire logic        break_active,
  input wire logic [5:0]  chan_capture_en,
  input wire logic [5:0]  chan_buffered,
  input wire logic [15:0] count_value,
  input wire logic        wrap_pulse,
  input wire logic        ext_pin_input_force,
  input wire logic        irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake
  ready_follows_a: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("pready held two cycles");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr outside access");
  ////////////////////////////////////////////////////////////////////////////
  // Counter and channel behaviour
  buffer_limit_a: assert property ((chan_buffered & ~TCP_BUF_CAPABLE) == 0)
    else $error("buffered on incapable channel");
  break_freeze_a: assert property (break_active[*2] |=> $stable(count_value))
    else $error("counter moved in break");
  capture_block_a: assert property (break_active[*2] |-> !chan_capture_en)
    else $error("capture allowed in break");
  count_step_a: assert property ($changed(count_value) |->
    count_value == $past(count_value) + 16'h1 || count_value == 16'h0)
    else $error("counter jumped");
  pulse_single_a: assert property (wrap_pulse |=> !wrap_pulse)
    else $error("wrap pulse too long");
  force_by_write_a: assert property ($changed(ext_pin_input_force) |->
    $past(pready) || $past(pready, 2))
    else $error("pin direction changed without write");
  // Main scenarios reached
  wrap_seen_c: cover property (wrap_pulse);
  irq_seen_c: cover property ($rose(irq));
  refuse_seen_c: cover property (pslverr);
  break_seen_c: cover property (break_active[*3]);
endmodule

// *** tb/tcp_core_tb_top.sv ***
// Self-checking bench for the timer counter core
`timescale 1ns/1ps
module tcp_core_tb_top
  import tcp_pkg::*;
;
  logic         clock = 1'h0, resetn = 1'h0;
  logic         psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0, prdata, d;
  logic         pready, pslverr, last_err;
  logic         break_active = 1'h0, break_clear_enable = 1'h0;
  logic         ext_timer_clock_pin = 1'h0;
  tcp_chan_ev_t chan_ev = '0;
  logic [5:0]   chan_capture_en, chan_buffered;
  logic [15:0]  count_value, c;
  logic         wrap_pulse, ext_pin_input_force, irq;
  int           num_errors = 0, n_checks = 0, cycles = 0;

  tcp_core uut (.clock, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .break_active, .break_clear_enable,
    .ext_timer_clock_pin, .chan_ev, .chan_capture_en, .chan_buffered,
    .count_value, .wrap_pulse, .ext_pin_input_force, .irq);

  // Clock and hang guard
  always #4 clock = ~clock;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One APB transfer; read data lands in d
  task automatic apb(input logic [7:0] i, input logic wr, input logic [31:0] v);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= {2'h0, i, 2'h0};
    pwdata  <= v;
    @(posedge clock);
    penable <= 1'h1;
    do begin
      @(posedge clock);
    end while (pready !== 1'h1);
    d        = prdata;
    last_err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clock);
  endtask
  task automatic wr(input logic [7:0] i, input logic [31:0] v);
    apb(i, 1'h1, v);
  endtask
  task automatic rd(input logic [7:0] i, input logic [31:0] e, input string w);
    apb(i, 1'h0, 32'h0);
    chk(w, d, e);
  endtask
  task automatic rdcnt();
    apb(TCP_IDX_CNT_HIGH, 1'h0, 32'h0);
    c[15:8] = d[7:0];
    apb(TCP_IDX_CNT_LOW, 1'h0, 32'h0);
    c[7:0] = d[7:0];
  endtask
  task automatic wait_irq();
    int t = 0;
    while (irq !== 1'h1 && t < 300) begin
      @(posedge clock);
      t++;
    end
    chk("irq", irq, 1'h1);
  endtask
  task automatic pulse(input logic [5:0] m);
    chan_ev.capture <= m;
    @(posedge clock);
    chan_ev.capture <= 6'h0;
    tick(3);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_latch();
    rd(TCP_IDX_STATUS, 32'h20, "status");
    rd(TCP_IDX_WRAP_HIGH, 32'hFF, "limit high");
    rd(TCP_IDX_WRAP_LOW, 32'hFF, "limit low");
    tick(10);
    rdcnt();
    chk("halted count", c, 32'h0);
    apb(8'h30, 1'h0, 32'h0);
    chk("unmapped", last_err, 1'h1);
    wr(TCP_IDX_STATUS, 32'h30);
    apb(TCP_IDX_CNT_HIGH, 1'h0, 32'h0);
    wr(TCP_IDX_STATUS, 32'h00);
    tick(40);
    wr(TCP_IDX_STATUS, 32'h20);
    rd(TCP_IDX_CNT_LOW, 32'h0, "latched low");
    apb(TCP_IDX_CNT_LOW, 1'h0, 32'h0);
    chk("live low", d > 32'h8, 1'h1);
    wr(TCP_IDX_STATUS, 32'h30);
    tick(5);
    rdcnt();
    chk("halt with clear", c, 32'h0);
    $display("test reset and latch done");
  endtask
  task automatic t_select();
    int e;
    for (int n = 0; n < 7; n++) begin
      wr(TCP_IDX_STATUS, 32'h30 | n);
      wr(TCP_IDX_STATUS, n);
      tick(256);
      wr(TCP_IDX_STATUS, 32'h20 | n);
      rdcnt();
      e = 258 >> n;
      chk("divided count", c + 2 >= e && c <= e + 2, 1'h1);
    end
    wr(TCP_IDX_MODE_CTRL, 32'h4);
    tick(2);
    chk("pin output", ext_pin_input_force, 1'h0);
    wr(TCP_IDX_STATUS, 32'h37);
    wr(TCP_IDX_STATUS, 32'h07);
    tick(2);
    chk("pin input", ext_pin_input_force, 1'h1);
    repeat (10) begin
      ext_timer_clock_pin <= 1'h1;
      tick(TCP_EXT_MIN_CYCLES);
      ext_timer_clock_pin <= 1'h0;
      tick(TCP_EXT_MIN_CYCLES);
    end
    wr(TCP_IDX_STATUS, 32'h20);
    tick(2);
    chk("pin free", ext_pin_input_force, 1'h0);
    rdcnt();
    chk("edge count", c, 32'hA);
    $display("test clock select done");
  endtask
  task automatic t_wrap_wait();
    wr(TCP_IDX_STATUS, 32'h30);
    wr(TCP_IDX_WRAP_HIGH, 32'h0);
    wr(TCP_IDX_STATUS, 32'h40);
    tick(300);
    rd(TCP_IDX_STATUS, 32'h40, "inhibited");
    wr(TCP_IDX_STATUS, 32'h70);
    wr(TCP_IDX_WRAP_LOW, 32'h10);
    wr(TCP_IDX_STATUS, 32'h40);
    wait_irq();
    wr(TCP_IDX_STATUS, 32'h60);
    rd(TCP_IDX_STATUS, 32'hE0, "flag kept");
    rdcnt();
    chk("restarted", c <= 16'h10, 1'h1);
    wr(TCP_IDX_STATUS, 32'h60);
    rd(TCP_IDX_STATUS, 32'h60, "flag cleared");
    chk("irq low", irq, 1'h0);
    wr(TCP_IDX_STATUS, 32'h70);
    wr(TCP_IDX_STATUS, 32'h40);
    wr(TCP_IDX_MODE_CTRL, 32'h1);
    apb(TCP_IDX_STATUS, 1'h0, 32'h0);
    chk("blocked", last_err, 1'h1);
    wait_irq();
    rd(TCP_IDX_MODE_CTRL, 32'h0, "woken");
    $display("test wrap and wait done");
  endtask
  task automatic t_break();
    wr(TCP_IDX_STATUS, 32'h60);
    rd(TCP_IDX_STATUS, 32'hE0, "armed");
    break_active <= 1'h1;
    wr(TCP_IDX_STATUS, 32'h60);
    rd(TCP_IDX_STATUS, 32'hE0, "protected");
    break_active <= 1'h0;
    wr(TCP_IDX_STATUS, 32'h60);
    rd(TCP_IDX_STATUS, 32'h60, "second step");
    wr(TCP_IDX_STATUS, 32'h40);
    wait_irq();
    break_active       <= 1'h1;
    break_clear_enable <= 1'h1;
    rd(TCP_IDX_STATUS, 32'hC0, "set in break");
    wr(TCP_IDX_STATUS, 32'h60);
    break_active       <= 1'h0;
    break_clear_enable <= 1'h0;
    rd(TCP_IDX_STATUS, 32'h60, "stays clear");
    wr(TCP_IDX_CHAN_CTRL, 32'h003F_0202);
    tick(2);
    chk("buffered", chan_buffered, 6'h15);
    pulse(6'h02);
    rd(TCP_IDX_CHAN_FLAGS, 32'h0, "halted capture");
    wr(TCP_IDX_STATUS, 32'h00);
    break_active <= 1'h1;
    pulse(6'h02);
    rd(TCP_IDX_CHAN_FLAGS, 32'h0, "break capture");
    break_active <= 1'h0;
    tick(3);
    pulse(6'h02);
    rd(TCP_IDX_CHAN_FLAGS, 32'h2, "capture flag");
    chk("channel irq", irq, 1'h1);
    $display("test break and capture done");
  endtask
  // Main sequence
  initial begin
    tick(20);
    resetn <= 1'h1;
    t_reset_latch();
    t_select();
    t_wrap_wait();
    t_break();
    print_verdict();
  end
endmodule

bind tcp_core tcp_core_monitor mon (.clock, .resetn, .psel, .penable,
  .pready, .pslverr, .break_active, .chan_capture_en, .chan_buffered,
  .count_value, .wrap_pulse, .ext_pin_input_force, .irq);
